/* File: include/ppe_pkg.sv */
// Package for the printer port with extended-capabilities FIFO
package ppe_pkg;

  // Base address choices and register offsets
  localparam logic [9:0]  BASE_LOW       = 10'h278;
  localparam logic [9:0]  BASE_HIGH      = 10'h378;
  localparam logic [10:0] OFS_DATA       = 11'h000;
  localparam logic [10:0] OFS_STATUS     = 11'h001;
  localparam logic [10:0] OFS_CONTROL    = 11'h002;
  localparam logic [10:0] OFS_FIFO       = 11'h400;
  localparam logic [10:0] OFS_CONFIG_B   = 11'h401;
  localparam logic [10:0] OFS_EXT_CTRL   = 11'h402;

  // Two-bit register selects on the low address lines
  localparam logic [1:0]  SEL_DATA       = 2'h0;
  localparam logic [1:0]  SEL_STATUS     = 2'h1;
  localparam logic [1:0]  SEL_CONTROL    = 2'h2;

  // Field positions
  localparam int          CTL_STROBE     = 0;
  localparam int          CTL_AUTOFEED   = 1;
  localparam int          CTL_INIT       = 2;
  localparam int          CTL_SELIN      = 3;
  localparam int          CTL_IRQEN      = 4;
  localparam int          CTL_DIR        = 5;
  localparam int          ENTRY_TYPE     = 7;

  // Constant bit fills and reset values
  localparam logic [2:0]  STATUS_LOW_ONES = 3'h7;
  localparam logic [2:0]  CTRL_HIGH_ONES  = 3'h7;
  localparam logic [5:0]  CTRL_RESET      = 6'h00;
  localparam logic [7:0]  CONFIG_A_VALUE  = 8'h10;
  localparam logic [7:0]  CONFIG_B_VALUE  = 8'h40;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;

  // Extended control modes
  typedef enum logic [2:0] {
    MODE_STANDARD = 3'h0,
    MODE_BIDIR    = 3'h1,
    MODE_FIFO_STD = 3'h2,
    MODE_ECP      = 3'h3,
    MODE_RESERVED = 3'h4,
    MODE_UNUSED   = 3'h5,
    MODE_TEST     = 3'h6,
    MODE_CONFIG   = 3'h7
  } ppe_mode_type;

  // Printer-side status inputs
  typedef struct packed {
    logic busy;
    logic ackLine;
    logic paperEmpty;
    logic printerSelected;
    logic errorLine;
  } ppe_status_type;

  // FIFO entry: tag marks command (address/run length) versus data
  typedef struct packed {
    logic       isCommand;
    logic [7:0] value;
  } ppe_entry_type;

endpackage : ppe_pkg

/* File: src/ppe_fifo.sv */
// Small synchronous FIFO for extended-capabilities transfers
`timescale 1ns/1ps
`default_nettype none
module ppe_fifo
  import ppe_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Control
  input  wire logic             flush,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("ppe_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wrPtr_ff;
  logic [AW:0]      rdPtr_ff;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (wrPtr_ff - rdPtr_ff) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_ff != rdPtr_ff;
  assign outData  = store[rdPtr_ff[AW-1:0]];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      store[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  // Flush wins so a change to standard or bidirectional mode leaves the FIFO empty
  always_ff @(posedge ref_clk) begin
    if (!rst_b || flush) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (doWrite) wrPtr_ff <= wrPtr_ff + 1'b1;
      if (doRead)  rdPtr_ff <= rdPtr_ff + 1'b1;
    end
  end
endmodule : ppe_fifo
`default_nettype wire

/* File: src/ppe_port.sv */
// Printer parallel port with extended-capabilities FIFO, register side and pins
//
// Functional notes
// - Data, status, control at base plus 0, 1, 2.
// - Port runs standard, bidirectional or ECP via extended control.
// - Data read returns the data lines; data write drives them except in FIFO-standard and ECP modes.
// - Status: bit7 busy inverted, 6 ack, 5 paper, 4 select, 3 error, 2:0 ones.
// - Control read: 7:5 ones, then irq enable, select-in, init, autofeed, strobe.
// - Control write sets strobe, autofeed, init, select-in, irq enable, direction.
// - Read decode: 00 data, 01 status, 10 control; 11 invalid.
// - Write decode: 00 data, 10 control; 01 and 11 invalid.
// - A 16-byte FIFO serves extended-capabilities transfers.
// - Base address decodes as 278h or 378h.
// - Address FIFO at 0; FIFOs and config A 400h, config B 401h, ext control 402h.
// - Address/run-length entry write-only; bit 7 set means channel address.
// - Bit 7 clear: run length, next data byte sent value plus one times.
// - Mode bits 7:5: standard, bidir, FIFO-standard, ECP, test, config; 100 reserved.
// - Irq enable set: interrupt on rising acknowledge edge; clear disables it.
// - ECP direction 1 tri-states data drivers; standard mode ignores direction.
`timescale 1ns/1ps
`default_nettype none
module ppe_port
  import ppe_pkg::*;
#(
  parameter int          FIFO_DEPTH = 16,
  parameter logic [9:0]  BASE_ADDR  = 10'h378
) (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst_b,
  // Host I/O bus
  input  wire logic [10:0]    ioAddr,
  input  wire logic           ioRead_b,
  input  wire logic           ioWrite_b,
  input  wire logic [7:0]     ioWrData,
  output logic [7:0]          ioRdData,
  output logic                ioRdValid,
  // Printer data lines
  input  wire logic [7:0]     portDataIn,
  output logic [7:0]          portDataOut,
  output logic                portDataOe,
  // Printer control lines
  output logic                strobeLine,
  output logic                autoFeed,
  output logic                initLine,
  output logic                selectInLine,
  // Printer status lines
  input  wire ppe_status_type printerStatus,
  // Interrupt request
  output logic                ackIrq
);
  if (FIFO_DEPTH != 16) begin : g_bad_depth
    $error("ppe_port: FIFO_DEPTH must be 16");
  end
  if (BASE_ADDR != BASE_LOW && BASE_ADDR != BASE_HIGH) begin : g_bad_base
    $error("ppe_port: bad BASE_ADDR");
  end

  // Registers
  logic [7:0]    portData_ff;
  logic [5:0]    control_ff;
  ppe_mode_type  mode_ff;
  logic          ackPrev_ff;
  logic [6:0]    repeatLeft_ff;
  logic          repeatArm_ff;
  logic [6:0]    repeatCount_ff;
  logic [7:0]    rdData_ff;
  logic          rdValid_ff;
  logic [7:0]    dataOut_ff;
  logic          dataOe_ff;
  logic [3:0]    lines_ff;
  logic          irq_ff;
  logic          readPrev_ff;
  logic          writePrev_ff;

  // Access decode
  logic          portSelect_n;
  logic [1:0]    lowSel;
  logic          rdStrobe;
  logic          wrStrobe;
  logic          inHighGroup;
  logic          extCtrlHit;

  // FIFO wiring
  ppe_entry_type fifoIn;
  ppe_entry_type fifoOut;
  logic          fifoInValid;
  logic          fifoInReady;
  logic          fifoOutValid;
  logic          fifoOutReady;
  logic          fifoFlush;
  logic          sendStep;
  logic          dataLast;

  // Access is one pulse at the leading edge of a strobe
  function automatic logic hitLow(input logic [10:0] addr, input logic [1:0] sel);
    hitLow = (addr[1:0] == sel) && !addr[10];
  endfunction : hitLow

  function automatic logic hitHigh(input logic [10:0] addr, input logic [1:0] sel);
    hitHigh = (addr[1:0] == sel) && addr[10];
  endfunction : hitHigh

  // Code 11 in the low group never selects, so it can neither answer nor write
  assign portSelect_n = !((ioAddr[9:2] == BASE_ADDR[9:2]) && !ioAddr[10] && ioAddr[1:0] != 2'h3) &&
                        !(ioAddr[10] && ioAddr[9:2] == BASE_ADDR[9:2]);
  assign lowSel       = ioAddr[1:0];
  assign inHighGroup  = ioAddr[10];
  assign rdStrobe     = !ioRead_b && ioWrite_b && readPrev_ff && !portSelect_n;
  assign wrStrobe     = !ioWrite_b && ioRead_b && writePrev_ff && !portSelect_n;
  assign extCtrlHit   = hitHigh(ioAddr, OFS_EXT_CTRL[1:0]);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      readPrev_ff  <= 1'b1;
      writePrev_ff <= 1'b1;
    end else begin
      readPrev_ff  <= ioRead_b;
      writePrev_ff <= ioWrite_b;
    end
  end

  // Data register; address FIFO shares offset 0 in ECP mode
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      portData_ff <= BYTE_ZERO;
    end else if (wrStrobe && hitLow(ioAddr, SEL_DATA) && mode_ff != MODE_ECP) begin
      portData_ff <= ioWrData;
    end
  end

  // Control register; bits 7:5 read back as ones regardless of what the host writes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      control_ff <= CTRL_RESET;
    end else if (wrStrobe && hitLow(ioAddr, SEL_CONTROL)) begin
      control_ff <= ioWrData[5:0];
    end
  end

  // Extended control mode; reserved codes are refused
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mode_ff <= MODE_STANDARD;
    end else if (wrStrobe && extCtrlHit) begin
      if (ioWrData[7:5] != MODE_RESERVED && ioWrData[7:5] != MODE_UNUSED) begin
        mode_ff <= ppe_mode_type'(ioWrData[7:5]);
      end
    end
  end

  // FIFO fill: command entries at offset 0, data entries at 400h
  always_comb begin
    fifoInValid = 1'b0;
    fifoIn      = '0;
    if (wrStrobe && mode_ff == MODE_ECP && hitLow(ioAddr, SEL_DATA)) begin
      fifoInValid = 1'b1;
      fifoIn      = '{isCommand: 1'b1, value: ioWrData};
    end else if (wrStrobe && hitHigh(ioAddr, OFS_FIFO[1:0]) &&
                 (mode_ff == MODE_ECP || mode_ff == MODE_FIFO_STD || mode_ff == MODE_TEST)) begin
      fifoInValid = 1'b1;
      fifoIn      = '{isCommand: 1'b0, value: ioWrData};
    end
  end

  // Standard and bidirectional modes hold the FIFO reset
  assign fifoFlush = mode_ff == MODE_STANDARD || mode_ff == MODE_BIDIR;

  ppe_fifo #(
    .WIDTH ($bits(ppe_entry_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .flush    (fifoFlush),
    .inValid  (fifoInValid),
    .inData   (fifoIn),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOut),
    .outReady (fifoOutReady)
  );

  // Drain one entry per cycle toward the lines; test mode drains only by host read
  assign sendStep     = fifoOutValid && (mode_ff == MODE_ECP || mode_ff == MODE_FIFO_STD) &&
                        !(mode_ff == MODE_ECP && control_ff[CTL_DIR]);
  // A data entry leaves only after its last repeat has stood on the lines
  assign dataLast     = repeatArm_ff ? repeatCount_ff == '0 : repeatLeft_ff == '0;
  assign fifoOutReady = (sendStep && (fifoOut.isCommand || dataLast)) ||
                        (rdStrobe && hitHigh(ioAddr, OFS_FIFO[1:0]) && mode_ff == MODE_TEST);

  // Run-length: a count entry arms a repeat for the next data byte
  always_ff @(posedge ref_clk) begin
    if (!rst_b || fifoFlush) begin
      repeatArm_ff   <= 1'b0;
      repeatCount_ff <= '0;
      repeatLeft_ff  <= '0;
    end else if (sendStep && fifoOut.isCommand && !fifoOut.value[ENTRY_TYPE]) begin
      repeatArm_ff   <= 1'b1;
      repeatCount_ff <= fifoOut.value[6:0];
    end else if (sendStep && !fifoOut.isCommand) begin
      if (repeatArm_ff) begin
        repeatArm_ff  <= 1'b0;
        // Armed cycle is the first showing, so one fewer remains
        repeatLeft_ff <= (repeatCount_ff == '0) ? '0 : repeatCount_ff - 1'b1;
      end else if (repeatLeft_ff != '0) begin
        repeatLeft_ff <= repeatLeft_ff - 1'b1;
      end
    end
  end

  // Data line drive; direction only matters in bidirectional and ECP modes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dataOut_ff <= BYTE_ZERO;
      dataOe_ff  <= 1'b0;
    end else begin
      if (sendStep && !fifoOut.isCommand) begin
        dataOut_ff <= fifoOut.value;
      end else if (sendStep && fifoOut.value[ENTRY_TYPE]) begin
        dataOut_ff <= fifoOut.value;
      end else if (mode_ff != MODE_ECP && mode_ff != MODE_FIFO_STD) begin
        dataOut_ff <= portData_ff;
      end
      case (mode_ff)
        MODE_STANDARD, MODE_FIFO_STD: dataOe_ff <= 1'b1;
        MODE_BIDIR, MODE_ECP:         dataOe_ff <= !control_ff[CTL_DIR];
        default:                      dataOe_ff <= 1'b1;
      endcase
    end
  end

  // Control lines and acknowledge interrupt
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lines_ff   <= '0;
      ackPrev_ff <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      lines_ff   <= control_ff[CTL_SELIN:CTL_STROBE];
      ackPrev_ff <= printerStatus.ackLine;
      irq_ff     <= control_ff[CTL_IRQEN] && printerStatus.ackLine && !ackPrev_ff;
    end
  end

  // Read data; invalid codes return zero and no valid flag
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdData_ff  <= BYTE_ZERO;
      rdValid_ff <= 1'b0;
    end else begin
      rdData_ff  <= BYTE_ZERO;
      rdValid_ff <= 1'b0;
      if (rdStrobe && !inHighGroup) begin
        rdValid_ff <= lowSel != 2'h3;
        case (lowSel)
          SEL_DATA:    rdData_ff <= portDataIn;
          SEL_STATUS:  rdData_ff <= {!printerStatus.busy, printerStatus.ackLine, printerStatus.paperEmpty,
                                     printerStatus.printerSelected, printerStatus.errorLine,
                                     STATUS_LOW_ONES};
          SEL_CONTROL: rdData_ff <= {CTRL_HIGH_ONES, control_ff[CTL_IRQEN:CTL_STROBE]};
          default:     rdData_ff <= BYTE_ZERO;
        endcase
      end else if (rdStrobe) begin
        rdValid_ff <= 1'b1;
        case (lowSel)
          OFS_FIFO[1:0]:     rdData_ff <= mode_ff == MODE_CONFIG ? CONFIG_A_VALUE :
                                          (mode_ff == MODE_TEST ? fifoOut.value : BYTE_ZERO);
          OFS_CONFIG_B[1:0]: rdData_ff <= mode_ff == MODE_CONFIG ? CONFIG_B_VALUE : BYTE_ZERO;
          OFS_EXT_CTRL[1:0]: rdData_ff <= {mode_ff, !fifoInReady, !fifoOutValid, 3'h0};
          default: begin
            rdData_ff  <= BYTE_ZERO;
            rdValid_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  assign ioRdData     = rdData_ff;
  assign ioRdValid    = rdValid_ff;
  assign portDataOut  = dataOut_ff;
  assign portDataOe   = dataOe_ff;
  assign strobeLine   = lines_ff[CTL_STROBE];
  assign autoFeed     = lines_ff[CTL_AUTOFEED];
  assign initLine     = lines_ff[CTL_INIT];
  assign selectInLine = lines_ff[CTL_SELIN];
  assign ackIrq       = irq_ff;
endmodule : ppe_port
`default_nettype wire

/* File: tb/ppe_port_props.sv */
// Checker for the printer port register side
`timescale 1ns/1ps
`default_nettype none
module ppe_port_props
  import ppe_pkg::*;
#(
  parameter logic [9:0] BASE_ADDR = 10'h378
) (
  // Clock and reset
  input wire logic           ref_clk,
  input wire logic           rst_b,
  // Host bus
  input wire logic [10:0]    ioAddr,
  input wire logic           ioRead_b,
  input wire logic           ioWrite_b,
  input wire logic [7:0]     ioWrData,
  input wire logic [7:0]     ioRdData,
  input wire logic           ioRdValid,
  // Printer side
  input wire logic           strobeLine,
  input wire logic           autoFeed,
  input wire logic           initLine,
  input wire logic           selectInLine,
  input wire ppe_status_type printerStatus,
  input wire logic           ackIrq
);
  logic rdHigh_ff;
  logic wrHigh_ff;
  logic hit;
  logic rdTake;
  logic wrTake;
  // Held high in reset so the first strobe after release counts as an edge
  always_ff @(posedge ref_clk) rdHigh_ff <= !rst_b | ioRead_b;
  always_ff @(posedge ref_clk) wrHigh_ff <= !rst_b | ioWrite_b;
  assign hit = ioAddr[9:2] == BASE_ADDR[9:2] && !ioAddr[10];
  assign rdTake = hit && !ioRead_b && rdHigh_ff && ioWrite_b;
  assign wrTake = hit && !ioWrite_b && wrHigh_ff && ioRead_b;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  rd_answer_a: assert property (rdTake && ioAddr[1:0] != 2'h3 |=> ioRdValid)
    else $error("valid read got no answer");
  rd_invalid_a: assert property (rdTake && ioAddr[1:0] == 2'h3 |=> !ioRdValid)
    else $error("invalid read answered");
  base_decode_a: assert property (!ioRead_b && ioAddr[9:2] != BASE_ADDR[9:2] |=> !ioRdValid)
    else $error("foreign address answered");
  rd_pulse_a: assert property (ioRdValid |=> !ioRdValid)
    else $error("read answer longer than one cycle");
  rd_idle_a: assert property (!ioRdValid |-> ioRdData == 8'h00)
    else $error("read data not zero when idle");
  status_bits_a: assert property (rdTake && ioAddr[1:0] == SEL_STATUS |=>
    ioRdData == {~$past(printerStatus.busy), $past(printerStatus[3:0]), 3'h7})
    else $error("status byte wrong");
  ctrl_ones_a: assert property (rdTake && ioAddr[1:0] == SEL_CONTROL |=> ioRdData[7:5] == 3'h7)
    else $error("control high bits not ones");
  ctrl_lines_a: assert property (wrTake && ioAddr[1:0] == SEL_CONTROL |-> ##2
    {selectInLine, initLine, autoFeed, strobeLine} == $past(ioWrData[3:0], 2))
    else $error("control lines do not follow write");
  irq_source_a: assert property (ackIrq |-> $past(printerStatus.ackLine))
    else $error("interrupt without acknowledge high");
  irq_pulse_a: assert property (ackIrq |=> !ackIrq)
    else $error("interrupt longer than one cycle");
endmodule : ppe_port_props
`default_nettype wire

bind ppe_port ppe_port_props #(.BASE_ADDR(BASE_ADDR)) u_props (.ref_clk(ref_clk), .rst_b(rst_b),
  .ioAddr(ioAddr), .ioRead_b(ioRead_b), .ioWrite_b(ioWrite_b), .ioWrData(ioWrData),
  .ioRdData(ioRdData), .ioRdValid(ioRdValid), .strobeLine(strobeLine), .autoFeed(autoFeed),
  .initLine(initLine), .selectInLine(selectInLine), .printerStatus(printerStatus), .ackIrq(ackIrq));

/* File: tb/ppe_printer_model.sv */
// Printer-side model: status levels and peripheral data drive
`timescale 1ns/1ps
`default_nettype none
module ppe_printer_model
  import ppe_pkg::*;
(
  // Port pins
  input wire logic [7:0]     portDataOut,
  input wire logic           portDataOe,
  // Bench-set peripheral state
  input wire ppe_status_type stsSet,
  input wire logic [7:0]     periphByte,
  // Pins back to the port
  output ppe_status_type     printerStatus,
  output logic [7:0]         portDataIn
);
  // Status levels held steady between bench changes
  assign printerStatus = stsSet;
  // Peripheral always drives when the port lets go, so lines never float
  assign portDataIn = portDataOe ? portDataOut : periphByte;
endmodule : ppe_printer_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the printer port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ppe_pkg::*;
  localparam logic [9:0] BASE = 10'h278;
  logic ref_clk = 1'b0, rst_b = 1'b0, ioRead_b = 1'b1, ioWrite_b = 1'b1;
  logic ioRdValid, portDataOe, ackIrq, strobeLine, autoFeed, initLine, selectInLine;
  logic [10:0] ioAddr = 11'h000;
  logic [7:0] ioWrData = 8'h00, periphByte = 8'h00, ioRdData, portDataIn, portDataOut, d;
  logic [7:0] q[16];
  logic [7:0] expQ[$];
  logic [2:0] md[3] = '{3'h0, 3'h1, 3'h3};
  ppe_status_type stsSet = 5'h00, printerStatus;
  int errorCnt = 0, nChecks = 0, cycles = 0, irqCnt = 0, rlCnt = 0, n = 0;
  logic [7:0] rlByte = 8'h00;

  ppe_port #(.FIFO_DEPTH(16), .BASE_ADDR(BASE)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .ioAddr(ioAddr),
    .ioRead_b(ioRead_b), .ioWrite_b(ioWrite_b), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .ioRdValid(ioRdValid), .portDataIn(portDataIn), .portDataOut(portDataOut), .portDataOe(portDataOe),
    .strobeLine(strobeLine), .autoFeed(autoFeed), .initLine(initLine), .selectInLine(selectInLine),
    .printerStatus(printerStatus), .ackIrq(ackIrq));
  ppe_printer_model u_prn (.portDataOut(portDataOut), .portDataOe(portDataOe), .stsSet(stsSet),
    .periphByte(periphByte), .printerStatus(printerStatus), .portDataIn(portDataIn));

  initial forever #5 ref_clk = ~ref_clk;

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic [10:0] ad(input logic hi, input logic [1:0] s);
    return {hi, BASE[9:2], s};
  endfunction : ad

  // One strobe pulse, then idle so the next access sees a fresh edge
  task automatic io(input logic wr, input logic [10:0] a, input logic [7:0] v);
    ioAddr = a;
    ioWrData = v;
    if (wr) ioWrite_b = 1'b0;
    else ioRead_b = 1'b0;
    @(posedge ref_clk) #1;
    ioWrite_b = 1'b1;
    ioRead_b = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : io

  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    expQ.push_back(e);
    io(1'b0, a, 8'h00);
  endtask : rd

  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask : fin

  task automatic testDone();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : testDone

  // Read answers are matched against the oldest expectation
  always @(negedge ref_clk) begin
    cycles++;
    if (ackIrq === 1'b1) irqCnt++;
    if (portDataOut === rlByte) rlCnt++;
    if (ioRdValid === 1'b1) begin
      if (expQ.size() == 0) check("unexpected read", 8'h01, 8'h00);
      else check("read data", ioRdData, expQ.pop_front());
    end
    if (cycles == 4000) begin
      errorCnt++;
      testDone();
    end
  end

  initial begin
    void'($urandom(32'h8f8609e6));
    repeat (12) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    @(posedge ref_clk) #1;
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      io(1'b1, ad(1'b0, SEL_DATA), d);
      check("data enable", {7'h00, portDataOe}, 8'h01);
      io(1'b1, ad(1'b0, SEL_STATUS), ~d);
      io(1'b1, {1'b0, 10'h378}, ~d);
      io(1'b0, {1'b0, 10'h378}, 8'h00);
      rd(ad(1'b0, SEL_DATA), d);
    end
    fin("data");
    for (int i = 0; i < 4; i++) begin
      stsSet = 5'($urandom);
      rd(ad(1'b0, SEL_STATUS), {~stsSet.busy, stsSet[3:0], 3'h7});
      io(1'b0, ad(1'b0, 2'h3), 8'h00);
    end
    fin("status");
    for (int i = 0; i < 4; i++) begin
      d = 8'hc0 | 8'($urandom % 32);
      io(1'b1, ad(1'b0, SEL_CONTROL), d);
      check("lines", {4'h0, selectInLine, initLine, autoFeed, strobeLine}, {4'h0, d[3:0]});
      rd(ad(1'b0, SEL_CONTROL), {3'h7, d[4:0]});
    end
    fin("control");
    for (int en = 1; en >= 0; en--) begin
      io(1'b1, ad(1'b0, SEL_CONTROL), 8'hc0 | 8'(en << 4));
      stsSet.ackLine = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      irqCnt = 0;
      stsSet.ackLine = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      check("irq count", 8'(irqCnt), 8'(en));
    end
    fin("interrupt");
    io(1'b1, ad(1'b1, 2'h2), 8'he0);
    rd(ad(1'b1, 2'h0), CONFIG_A_VALUE);
    rd(ad(1'b1, 2'h1), CONFIG_B_VALUE);
    io(1'b1, ad(1'b1, 2'h2), 8'h80);
    rd(ad(1'b1, 2'h2), 8'he8);
    for (int i = 0; i < 3; i++) begin
      io(1'b1, ad(1'b1, 2'h2), {md[i], 5'h00});
      rd(ad(1'b1, 2'h2), {md[i], 5'h08});
      io(1'b1, ad(1'b0, SEL_CONTROL), 8'he0);
      check("data enable", {7'h00, portDataOe}, {7'h00, md[i] == MODE_STANDARD});
      io(1'b1, ad(1'b0, SEL_CONTROL), 8'hc0);
    end
    fin("modes");
    // Test mode holds bytes without sending, so the fill level is visible
    io(1'b1, ad(1'b1, 2'h2), 8'hc0);
    for (int i = 0; i < 16; i++) begin
      q[i] = 8'($urandom);
      io(1'b1, ad(1'b1, 2'h0), q[i]);
    end
    rd(ad(1'b1, 2'h2), 8'hd0);
    for (int i = 0; i < 16; i++) rd(ad(1'b1, 2'h0), q[i]);
    rd(ad(1'b1, 2'h2), 8'hc8);
    fin("fifo");
    // Run length: the next data byte stands on the lines count plus one cycles
    io(1'b1, ad(1'b1, 2'h2), {MODE_ECP, 5'h00});
    io(1'b1, ad(1'b0, SEL_DATA), 8'h85);
    check("channel address", portDataOut, 8'h85);
    n = int'($urandom % 7);
    rlByte = {1'b0, 7'($urandom)};
    io(1'b1, ad(1'b0, SEL_DATA), {1'b0, 7'(n)});
    rlCnt = 0;
    io(1'b1, ad(1'b1, 2'h0), rlByte);
    io(1'b1, ad(1'b1, 2'h0), rlByte ^ 8'h01);
    repeat (8) @(posedge ref_clk);
    #1;
    check("repeat count", 8'(rlCnt), 8'(n + 1));
    check("last byte", portDataOut, rlByte ^ 8'h01);
    fin("run length");
    repeat (3) @(posedge ref_clk);
    check("pending reads", 8'(expQ.size()), 8'h00);
    testDone();
  end
endmodule : tb
`default_nettype wire
